/* File: lhw_pkg.sv */
// package of constants and carriers for the lcd host write port
package lhw_pkg;
    // ****************************************************************
    // command decode
    // ****************************************************************
    localparam logic [3:0] CMD_POWER_SAVE   = 4'h4;
    localparam logic [3:0] CMD_POWER_CTRL   = 4'h5;
    localparam logic [3:0] CMD_DISPLAY_CTRL = 4'h3;
    localparam logic [3:0] CMD_CONTRAST_SET = 4'h6;
    localparam logic [3:0] CMD_SYSTEM_SET   = 4'h7;
    localparam logic [3:0] CMD_IFACE_WIDTH  = 4'h2;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int PWR_BOOST_BIT    = 0;
    localparam int PWR_FOLLOWER_BIT = 1;
    localparam int PWR_REGULATOR_BIT = 2;
    localparam int SAVE_PS_BIT      = 0;
    localparam int SAVE_OSC_BIT     = 1;
    localparam int SYS_CG_BIT       = 0;
    localparam int IFW_EIGHT_BIT    = 0;
    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [3:0] CONTRAST_RST  = 4'h0;
    localparam logic [3:0] DISPLAY_RST   = 4'h0;
    localparam logic       IF8_RST       = 1'b1;
    localparam logic [2:0] BITCNT_RST    = 3'h0;
    localparam logic [7:0] SHIFT_RST     = 8'h00;
    localparam logic       WR_IDLE_RST   = 1'b1;

    // one received byte with its steering bit
    typedef struct packed {
        logic       is_data;
        logic [7:0] value;
    } lhw_byte_s;

    // latched configuration state
    typedef struct packed {
        logic [3:0] display;
        logic       osc_on;
        logic       power_save;
        logic       boost_on;
        logic       follower_on;
        logic       regulator_on;
        logic       cg_ram_use;
        logic [3:0] contrast;
        logic       if8;
    } lhw_cfg_s;
endpackage : lhw_pkg

/* File: lhw_port.sv */
// write-only host port: parallel 68/80, 4-bit nibbles, serial link
// Contract
// - parallel when select high, serial when low
// - init level after edge picks 68/80 style
// - 80 style captures on write rising edge
// - steer high to data, low to command
// - 4-bit mode joins two nibbles into byte
// - bus width chosen by configuration command
// - serial uses 8-bit shifter, 3-bit counter
// - deselect clears shifter and counter
// - serial msb first on clock rise
// - eighth clock rise delivers the byte
// - steer sampled at every eighth clock
// - deselect ignores all bus inputs
// - init pin acts regardless of select
// - power stages enabled independently
// - power bits: boost, follower, regulator
// - contrast holds four bits, sixteen levels
// - contrast cleared by init or command
// - init turns all but width off, no cg ram
module lhw_port
    import lhw_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       serial_clk,
    input  wire logic       serial_in,
    input  wire logic       chip_select_n,
    input  wire logic       cmd_data_select,
    input  wire logic       write_strobe,
    input  wire logic [7:0] parallel_lines,
    input  wire logic       par_ser_select,
    input  wire logic       init_pin,
    output logic            byte_valid,
    output lhw_byte_s       byte_out,
    output logic            mode_68,
    output lhw_cfg_s        cfg
);
    // ****************************************************************
    // behaviour notes
    // ****************************************************************
    // two clock domains: link clock for the shifter, system clock else
    // the link side hands over a byte by flipping a toggle
    // the handover word stays put until the next eighth edge
    // so the system side may read it once the toggle is synced
    // hosts must space serial bytes well apart for that reason
    // chip select high clears the shifter without a link edge
    // a cut frame therefore never leaks bits into the next one
    // the steering bit rides with the byte through the handover
    // every pin the system logic decodes passes two system flops first; the link side takes its pins direct
    // parallel data is read only at a strobe end, long settled
    // the strobe end is found by comparing two synced samples
    // 80 style ends on a rising write, 68 style on a falling enable
    // the strobe flops reset high to match the 80 style idle level
    // so no false strobe end follows reset
    // the init pin is edge sensed in both directions
    // its level one cycle after the edge picks the bus style
    // an edge arriving while the last one is applied is kept
    // init clears display, power, contrast and cg ram use
    // init keeps the width setting but restarts the nibble phase
    // in 4-bit mode the first nibble only waits in a holding reg
    // the second nibble completes the byte and fires the pulse
    // a command byte updates the configuration in the same cycle
    // display data leaves the configuration untouched
    // byte_valid stands for one system cycle per byte
    // byte_out holds the last byte until the next one
    // unknown command codes are ignored
    // the power bits follow the host without sequencing checks
    // the host must start the oscillator before the boost stage
    // a noisy link clock may corrupt settings; hosts rewrite them
    // the width command is the only way to leave 8-bit mode
    // serial mode ignores the width setting altogether

    // ****************************************************************
    // serial link domain
    // ****************************************************************
    logic [7:0] shift;
    logic [2:0] bitcnt;
    lhw_byte_s  ser_hold;
    logic       ser_toggle;
    logic [7:0] next_shift;
    logic [2:0] next_bitcnt;
    lhw_byte_s  next_ser_hold;
    logic       next_ser_toggle;

    // shift in msb first, hand over on eighth edge
    always_comb begin
        next_shift      = {shift[6:0], serial_in};
        next_bitcnt     = bitcnt + 3'd1;
        next_ser_hold   = ser_hold;
        next_ser_toggle = ser_toggle;
        if (bitcnt == 3'd7) begin
            next_ser_hold.value   = {shift[6:0], serial_in};
            next_ser_hold.is_data = cmd_data_select;
            next_ser_toggle       = ~ser_toggle;
        end
    end

    // chip select high holds the shifter cleared
    always_ff @(posedge serial_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            shift  <= SHIFT_RST;
            bitcnt <= BITCNT_RST;
        end else begin
            shift  <= next_shift;
            bitcnt <= next_bitcnt;
        end
    end

    // handover word and event toggle survive deselect
    always_ff @(posedge serial_clk or negedge resetn) begin
        if (!resetn) begin
            ser_hold   <= '0;
            ser_toggle <= 1'b0;
        end else begin
            ser_hold   <= next_ser_hold;
            ser_toggle <= next_ser_toggle;
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // first stages: read by nothing but their second stage
    logic       tog_meta;
    logic       init_meta;
    logic       par_meta;
    logic       wr_meta;
    logic       a0_meta;
    logic       sel_meta;
    logic [7:0] pl1;
    // second stages: the only copies the system logic reads
    logic       s_tog;
    logic       s_init;
    logic       s_par;
    logic       s_wr;
    logic       s_a0;
    logic       s_sel;
    logic [7:0] pl2;

    // first stage of each pin; strobe parks at its 80 style idle level
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tog_meta  <= 1'b0;
            init_meta <= 1'b0;
            par_meta  <= 1'b0;
            wr_meta   <= WR_IDLE_RST;                            // no false edge after reset
            a0_meta   <= 1'b0;
            sel_meta  <= 1'b0;
            pl1       <= '0;
        end else begin
            tog_meta  <= ser_toggle;
            init_meta <= init_pin;
            par_meta  <= par_ser_select;
            wr_meta   <= write_strobe;
            a0_meta   <= cmd_data_select;
            sel_meta  <= ~chip_select_n;
            pl1       <= parallel_lines;
        end
    end

    // second stage of each pin
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_tog  <= 1'b0;
            s_init <= 1'b0;
            s_par  <= 1'b0;
            s_wr   <= WR_IDLE_RST;
            s_a0   <= 1'b0;
            s_sel  <= 1'b0;
            pl2    <= '0;
        end else begin
            s_tog  <= tog_meta;
            s_init <= init_meta;
            s_par  <= par_meta;
            s_wr   <= wr_meta;
            s_a0   <= a0_meta;
            s_sel  <= sel_meta;
            pl2    <= pl1;
        end
    end

    // ****************************************************************
    // system domain state
    // ****************************************************************
    logic      tog_seen;
    logic      wr_prev;
    logic      init_prev;
    logic      init_pend;
    logic      nib_half;
    logic [3:0] nib_hi;
    logic      next_tog_seen;
    logic      next_wr_prev;
    logic      next_init_prev;
    logic      next_init_pend;
    logic      next_nib_half;
    logic [3:0] next_nib_hi;
    logic      next_byte_valid;
    lhw_byte_s next_byte_out;
    logic      next_mode_68;
    lhw_cfg_s  next_cfg;
    logic      strobe_end;
    logic      init_edge;
    lhw_byte_s got;
    logic      got_valid;

    // function: apply a command byte to configuration
    function automatic lhw_cfg_s apply_cmd(input lhw_cfg_s c, input logic [7:0] b);
        lhw_cfg_s r;
        r = c;
        unique case (b[7:4])
            CMD_DISPLAY_CTRL: r.display = b[3:0];
            CMD_POWER_SAVE: begin
                r.osc_on     = b[SAVE_OSC_BIT];
                r.power_save = b[SAVE_PS_BIT];
            end
            CMD_POWER_CTRL: begin
                r.boost_on     = b[PWR_BOOST_BIT];
                r.follower_on  = b[PWR_FOLLOWER_BIT];
                r.regulator_on = b[PWR_REGULATOR_BIT];
            end
            CMD_CONTRAST_SET: r.contrast = b[3:0];
            CMD_SYSTEM_SET:   r.cg_ram_use = b[SYS_CG_BIT];
            CMD_IFACE_WIDTH:  r.if8 = b[IFW_EIGHT_BIT];
            default: r = c;
        endcase
        return r;
    endfunction : apply_cmd

    // function: configuration as the init pin leaves it, width kept
    function automatic lhw_cfg_s cleared_cfg(input lhw_cfg_s c);
        lhw_cfg_s r;
        r              = c;
        r.display      = DISPLAY_RST;
        r.osc_on       = 1'b0;
        r.power_save   = 1'b0;
        r.boost_on     = 1'b0;
        r.follower_on  = 1'b0;
        r.regulator_on = 1'b0;
        r.cg_ram_use   = 1'b0;
        r.contrast     = CONTRAST_RST;
        return r;
    endfunction : cleared_cfg

    // function: end of a write strobe in the selected bus style
    function automatic logic strobe_done(input logic m68, input logic prev, input logic now);
        logic r;
        if (m68) begin
            r = prev && !now;                                    // 68 style: enable falls
        end else begin
            r = !prev && now;                                    // 80 style: write rises
        end
        return r;
    endfunction : strobe_done

    // detect strobe end and init edge, assemble bytes, update config
    always_comb begin
        next_tog_seen  = s_tog;
        next_wr_prev   = s_wr;
        next_init_prev = s_init;
        next_init_pend = init_pend;
        next_nib_half  = nib_half;
        next_nib_hi    = nib_hi;
        next_mode_68   = mode_68;
        next_cfg       = cfg;
        next_byte_out  = byte_out;
        next_byte_valid = 1'b0;
        got            = '0;
        got_valid      = 1'b0;
        // 68 style ends on enable fall, 80 style on write rise
        strobe_end = strobe_done(mode_68, wr_prev, s_wr);
        init_edge  = (s_init != init_prev);
        if (init_edge) begin
            next_init_pend = 1'b1;
        end
        if (init_pend) begin
            // settled level after the edge selects bus style
            next_mode_68   = s_init;
            next_init_pend = init_edge;                          // a fresh edge is kept
            next_nib_half  = 1'b0;
            next_cfg       = cleared_cfg(cfg);
        end else if (!s_par) begin
            if (s_tog != tog_seen) begin
                got       = ser_hold;
                got_valid = 1'b1;
            end
        end else if (s_sel && strobe_end) begin
            if (cfg.if8) begin
                got.value   = pl2;
                got.is_data = s_a0;
                got_valid   = 1'b1;
            end else if (!nib_half) begin
                next_nib_hi   = pl2[7:4];
                next_nib_half = 1'b1;
            end else begin
                got.value     = {nib_hi, pl2[7:4]};
                got.is_data   = s_a0;
                got_valid     = 1'b1;
                next_nib_half = 1'b0;
            end
        end
        if (got_valid) begin
            next_byte_out   = got;
            next_byte_valid = 1'b1;
            if (!got.is_data) begin
                next_cfg = apply_cmd(cfg, got.value);
            end
        end
    end

    // register system domain state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tog_seen   <= 1'b0;
            wr_prev    <= WR_IDLE_RST;
            init_prev  <= 1'b0;
            init_pend  <= 1'b1;
            nib_half   <= 1'b0;
            nib_hi     <= 4'h0;
            byte_valid <= 1'b0;
            byte_out   <= '0;
            mode_68    <= 1'b0;
            cfg        <= '{display: DISPLAY_RST, contrast: CONTRAST_RST,
                            if8: IF8_RST, default: 1'b0};
        end else begin
            tog_seen   <= next_tog_seen;
            wr_prev    <= next_wr_prev;
            init_prev  <= next_init_prev;
            init_pend  <= next_init_pend;
            nib_half   <= next_nib_half;
            nib_hi     <= next_nib_hi;
            byte_valid <= next_byte_valid;
            byte_out   <= next_byte_out;
            mode_68    <= next_mode_68;
            cfg        <= next_cfg;
        end
    end
endmodule : lhw_port

/* File: lhw_port_assertions.sv */
// assertions on the write port outputs
module lhw_port_assertions
    import lhw_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      resetn,
    input wire logic      chip_select_n,
    input wire logic      init_pin,
    input wire logic      byte_valid,
    input wire lhw_byte_s byte_out,
    input wire logic      mode_68,
    input wire lhw_cfg_s  cfg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // command byte of code c delivered now
    sequence s_cmd(c);
        byte_valid && !byte_out.is_data && byte_out.value[7:4] == c;
    endsequence
    // init level moved, then held while init settles
    sequence s_init;
        $changed(init_pin) ##1 $stable(init_pin) [*5];
    endsequence
    a_pulse_once: assert property (byte_valid |=> !byte_valid)
        else $error("byte pulse too wide");
    a_desel_quiet: assert property (chip_select_n [*8] |-> !byte_valid)
        else $error("byte while deselected");
    a_power_bits: assert property (s_cmd(CMD_POWER_CTRL) |->
        cfg.boost_on == byte_out.value[0] && cfg.follower_on == byte_out.value[1]
        && cfg.regulator_on == byte_out.value[2]) else $error("power bits wrong");
    a_contrast_load: assert property (s_cmd(CMD_CONTRAST_SET) |->
        cfg.contrast == byte_out.value[3:0]) else $error("contrast not loaded");
    a_contrast_src: assert property ($changed(cfg.contrast) |->
        s_cmd(CMD_CONTRAST_SET) or (cfg.contrast == CONTRAST_RST))
        else $error("contrast changed alone");
    a_data_keep: assert property (byte_valid && byte_out.is_data |-> $stable(cfg))
        else $error("data byte changed config");
    a_init_clear: assert property (s_init |-> cfg[14:1] == 14'h0000)
        else $error("init left config set");
    a_mode_pick: assert property (s_init |-> mode_68 == init_pin)
        else $error("bus style not taken from init");
endmodule : lhw_port_assertions

/* File: lhw_host.sv */
// processor model driving the write port pins
module lhw_host (
    input  wire logic  clk_sys,
    output logic       serial_clk,
    output logic       serial_in,
    output logic       chip_select_n,
    output logic       cmd_data_select,
    output logic       write_strobe,
    output logic [7:0] parallel_lines,
    output logic       par_ser_select,
    output logic       init_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lclk;
    logic sen;
    logic m68;
    // link clock reaches the pin only inside frames
    assign serial_clk = sen & lclk;
    initial begin
        {serial_in, cmd_data_select, par_ser_select, init_pin, sen, m68, lclk} = '0;
        {chip_select_n, write_strobe} = 2'h3;
        parallel_lines = 8'h00;
        #13;
        forever #40 lclk = ~lclk;
    end
    // one strobe; s low keeps the port deselected
    task automatic wr(input logic s, input logic d, input logic [7:0] v);
        @(posedge clk_sys);
        par_ser_select <= 1'b1;
        chip_select_n <= ~s;
        cmd_data_select <= d;
        parallel_lines <= v;
        write_strobe <= m68;
        repeat (3) @(posedge clk_sys);
        write_strobe <= ~m68;
        repeat (5) @(posedge clk_sys);
        chip_select_n <= 1'b1;
        parallel_lines <= ~v;
        repeat (4) @(posedge clk_sys);
    endtask : wr
    // serial frame of n bits, msb first
    task automatic ser(input logic d, input logic [7:0] v, input int n);
        @(negedge lclk);
        par_ser_select <= 1'b0;
        chip_select_n <= 1'b0;
        cmd_data_select <= d;
        for (int i = 7; i > 7 - n; i--) begin
            @(negedge lclk);
            serial_in <= v[i];
            sen <= 1'b1;
        end
        @(negedge lclk);
        sen <= 1'b0;
        serial_in <= ~serial_in;
        @(negedge lclk);
        chip_select_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : ser
    // init edge; strobe parked at its new idle level first
    task automatic mode(input logic m);
        @(posedge clk_sys);
        m68 <= m;
        write_strobe <= ~m;
        repeat (2) @(posedge clk_sys);
        chip_select_n <= 1'b0;
        init_pin <= m;
        repeat (8) @(posedge clk_sys);
        chip_select_n <= 1'b1;
    endtask : mode
endmodule : lhw_host

/* File: lhw_port_bench.sv */
// self-checking bench for the host write port
module lhw_port_bench;
    import lhw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys;
    logic       resetn;
    logic       serial_clk, serial_in, chip_select_n, cmd_data_select;
    logic       write_strobe, par_ser_select, init_pin, byte_valid, mode_68;
    logic [7:0] parallel_lines;
    lhw_byte_s  byte_out;
    lhw_byte_s  got = '0;
    lhw_cfg_s   cfg;
    logic [7:0] n_got = 8'h00;
    logic [7:0] n_exp = 8'h00;
    int         err_total = 0;
    int         num_checks = 0;
    int         cyc = 0;
    // rows {path, is_data, value}: 0 par8, 1 serial, 2 par4
    logic [10:0] rows [11] = '{11'h03F, 11'h043, 11'h055, 11'h06A, 11'h071, 11'h1A5,
        11'h26F, 11'h33C, 11'h020, 11'h596, 11'h421};
    lhw_host host (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_in(serial_in),
        .chip_select_n(chip_select_n), .cmd_data_select(cmd_data_select),
        .write_strobe(write_strobe), .parallel_lines(parallel_lines),
        .par_ser_select(par_ser_select), .init_pin(init_pin));
    lhw_port dut (.clk_sys(clk_sys), .resetn(resetn), .serial_clk(serial_clk),
        .serial_in(serial_in), .chip_select_n(chip_select_n),
        .cmd_data_select(cmd_data_select), .write_strobe(write_strobe),
        .parallel_lines(parallel_lines), .par_ser_select(par_ser_select),
        .init_pin(init_pin), .byte_valid(byte_valid), .byte_out(byte_out),
        .mode_68(mode_68), .cfg(cfg));
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // record delivered bytes, cut a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (byte_valid === 1'b1) begin
            got <= byte_out;
            n_got <= n_got + 8'h01;
        end
        if (cyc == 5000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input logic [16:0] a, input logic [16:0] e);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, a, e);
        end
    endtask : chk
    task automatic send(input logic [10:0] r);
        case (r[10:9])
            2'h1: host.ser(r[8], r[7:0], 8);
            2'h2: begin
                host.wr(1'b1, r[8], r[7:0]);
                host.wr(1'b1, r[8], {r[3:0], r[7:4]});
            end
            default: host.wr(1'b1, r[8], r[7:0]);
        endcase
        n_exp++;
    endtask : send
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        resetn = 1'b0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(cfg, 17'h0_0001);
        chk({16'h0000, mode_68}, 17'h0_0000);
        $display("reset test done");
        foreach (rows[k]) begin
            send(rows[k]);
            chk({n_got, got}, {n_exp, rows[k][8:0]});
        end
        chk(cfg, 17'h0_7F7F);
        $display("row test done");
        host.wr(1'b0, 1'b0, 8'h65);
        chk({n_got, got}, {n_exp, 9'h021});
        host.ser(1'b0, 8'hFF, 4);
        send(11'h26C);
        chk({n_got, got}, {n_exp, 9'h06C});
        $display("deselect test done");
        host.mode(1'b1);
        chk(cfg, 17'h0_0001);
        chk({16'h0000, mode_68}, 17'h0_0001);
        send(11'h067);
        chk(cfg, 17'h0_000F);
        send(11'h060);
        chk(cfg, 17'h0_0001);
        $display("init test done");
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(cfg, 17'h0_0001);
        chk({16'h0000, mode_68}, 17'h0_0001);
        $display("mid reset test done");
        stop_test();
    end
endmodule : lhw_port_bench

bind lhw_port lhw_port_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
    .chip_select_n(chip_select_n), .init_pin(init_pin), .byte_valid(byte_valid),
    .byte_out(byte_out), .mode_68(mode_68), .cfg(cfg));
